// ### hw/owc_pkg.sv
// Function
// [R01] Before a switch to the slow clock, software turns the slow oscillator on and only then starts the pair.
// [R02] Before a switch to the fast clock, software turns the fast oscillator on and only then starts the pair.
// [R03] The pair counts up from the moment the run bit of the upper counter control is written to one.
// [R04] When the up-counter meets the 16-bit period comparator the counter clears and the match request is raised.
// [R05] After the match on a fast-to-slow switch, software stops the pair, selects the slow clock, then stops the fast one.
// [R06] After the match on a slow-to-fast switch, software stops the pair, selects the fast clock, then stops the slow one.
// [R07] With a 32.768 kHz slow source, comparator 0100H gives 7.81 ms and FF00H gives 1.99 s.
// [R08] From the fast source, comparator 0100H gives 16 us and FF00H gives 4.08 ms.
// [R09] Writing 43H to the lower counter control picks the slow source, 16-bit cascade and a cleared output flop.
// [R10] Writing 63H to the lower counter control picks the fast source, 16-bit cascade and a cleared output flop.
// [R11] Writing 05H to the upper counter control picks warm-up mode, output flop at zero, pair not running.
// [R12] Bit 3 of the upper counter control is the run bit; clearing it stops the pair.
// [R13] System control two: bit 5 selects the system clock, bit 6 enables the slow and bit 7 the fast oscillator.
// [R14] In warm-up mode only the upper eight comparator bits take part in the match; the lower eight are ignored.
// [R15] Software keeps both output flop bits at zero in warm-up mode, or the pulse pins may toggle.
// [R16] Clearing the run bit also clears the up-counter, so the next start times a fresh interval.
package owc_pkg;

  // ==========================================================================
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_LOWER_CTL   = 8'h00;
  localparam logic [7:0] OFS_UPPER_CTL   = 8'h04;
  localparam logic [7:0] OFS_PERIOD      = 8'h08;
  localparam logic [7:0] OFS_SYSCTL_TWO  = 8'h0c;
  localparam logic [7:0] OFS_COUNT       = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;

  // ==========================================================================
  // field positions
  localparam int MODE_LSB        = 0;
  localparam int MODE_MSB        = 2;
  localparam int RUN_BIT         = 3;
  localparam int CLKSEL_LSB      = 4;
  localparam int CLKSEL_MSB      = 6;
  localparam int OUT_FLOP_BIT    = 7;
  localparam int SYSCLK_SEL_BIT  = 5;
  localparam int SLOW_OSC_BIT    = 6;
  localparam int FAST_OSC_BIT    = 7;
  localparam int MATCH_IRQ_BIT   = 0;

  // ==========================================================================
  // field encodings
  localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;
  localparam logic [2:0] UPPER_MODE_WARMUP  = 3'h5;
  localparam logic [2:0] CLKSEL_SLOW        = 3'h4;
  localparam logic [2:0] CLKSEL_FAST        = 3'h6;

  // ==========================================================================
  // values after reset
  localparam logic [7:0]  LOWER_CTL_RESET  = 8'h00;
  localparam logic [7:0]  UPPER_CTL_RESET  = 8'h00;
  localparam logic [15:0] PERIOD_RESET     = 16'h0000;
  localparam logic [7:0]  SYSCTL_RESET     = 8'h80;
  localparam logic        IRQ_STATUS_RESET = 1'b0;
  localparam logic        IRQ_MASK_RESET   = 1'b0;

endpackage : owc_pkg

// ### hw/owc_count8.sv
`timescale 1ns/1ps
module owc_count8
  import owc_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             step,
  output logic      [WIDTH-1:0] count,
  output logic                  carry
);

  // ==========================================================================
  // state
  typedef struct packed
  {
    logic [WIDTH-1:0] count;
  } owc_stage_t;

  owc_stage_t state;
  owc_stage_t next_state;

  always_comb
  begin
    next_state = state;
    if (clear)
    begin
      next_state.count = '0;
    end
    else if (step)
    begin
      next_state.count = state.count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // carry feeds the next stage of the cascade
  assign count = state.count;
  assign carry = step & (&state.count);

endmodule // owc_count8

// ### hw/owc_warmup.sv
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
module owc_warmup
  import owc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic        slow_clock_tick,
  input  wire logic        fast_clock_tick,
  output logic             pair_match_irq,
  output logic             pair_running,
  output logic             system_clock_select,
  output logic             slow_osc_enable,
  output logic             fast_osc_enable,
  output logic             lower_output_flop,
  output logic             upper_output_flop
);

  // ==========================================================================
  // state
  typedef struct packed
  {
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  lower_counter_control;
    logic [7:0]  upper_counter_control;
    logic [7:0]  period_compare_high;
    logic [7:0]  period_compare_low;
    logic [7:0]  system_control_two;
    logic        irq_status;
    logic        irq_mask;
  } owc_regs_t;

  owc_regs_t state;
  owc_regs_t next_state;

  logic [7:0]  count_low;
  logic [7:0]  count_high;
  logic        carry_low;
  logic [15:0] count_value;
  logic [15:0] count_plus;
  logic        run_bit;
  logic        mode_ok;
  logic        source_tick;
  logic        step;
  logic        match;
  logic        clear_pair;
  logic        access;
  logic        wr_strobe;
  logic [31:0] read_word;

  // ==========================================================================
  // counting
  assign run_bit = state.upper_counter_control[RUN_BIT];

  // other timer modes are not built; the pair only counts in warm-up cascade
  assign mode_ok = (state.upper_counter_control[MODE_MSB:MODE_LSB] == UPPER_MODE_WARMUP)
                 & (state.lower_counter_control[MODE_MSB:MODE_LSB] == LOWER_MODE_CASCADE); // [R11]

  always_comb
  begin
    source_tick = 1'b0;
    unique case (state.lower_counter_control[CLKSEL_MSB:CLKSEL_LSB])
      CLKSEL_SLOW: source_tick = slow_clock_tick; // [R09]
      CLKSEL_FAST: source_tick = fast_clock_tick; // [R10]
      default:     source_tick = 1'b0;
    endcase
  end

  assign step        = run_bit & mode_ok & source_tick; // [R03]
  assign count_value = {count_high, count_low};
  assign count_plus  = count_value + 16'h0001;

  // low comparator byte ignored: interval is compare_high * 256 source ticks, or one tick when compare_high is zero
  assign match = step & (count_plus[15:8] == state.period_compare_high); // [R14] [R07] [R08]

  // clears on match and whenever stopped, so each start times afresh
  assign clear_pair = match | ~run_bit; // [R04] [R12] [R16]

  owc_count8 #(
    .WIDTH (8)
  ) u_lower (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (clear_pair),
    .step  (step),
    .count (count_low),
    .carry (carry_low)
  );

  owc_count8 #(
    .WIDTH (8)
  ) u_upper (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (clear_pair),
    .step  (carry_low),
    .count (count_high),
    .carry ()
  );

  // ==========================================================================
  // wishbone slave
  assign access    = wb_cyc & wb_stb;
  // write lands on the edge where the master samples ack
  assign wr_strobe = access & wb_we & state.ack;

  always_comb
  begin
    read_word = 32'h0000_0000;
    unique case (wb_adr)
      OFS_LOWER_CTL:  read_word[7:0]  = state.lower_counter_control;
      OFS_UPPER_CTL:  read_word[7:0]  = state.upper_counter_control;
      OFS_PERIOD:     read_word[15:0] = {state.period_compare_high, state.period_compare_low};
      OFS_SYSCTL_TWO: read_word[7:0]  = state.system_control_two;
      OFS_COUNT:      read_word[15:0] = count_value;
      OFS_IRQ_STATUS: read_word[MATCH_IRQ_BIT] = state.irq_status;
      OFS_IRQ_MASK:   read_word[MATCH_IRQ_BIT] = state.irq_mask;
      default:        read_word = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_state = state;

    // one wait cycle, ack for one cycle, then low again
    next_state.ack = access & ~state.ack;
    if (access & ~state.ack & ~wb_we)
    begin
      next_state.rdata = read_word;
    end

    if (wr_strobe)
    begin
      unique case (wb_adr)
        OFS_LOWER_CTL:
        begin
          if (wb_sel[0])
          begin
            next_state.lower_counter_control = wb_dat_w[7:0]; // [R09] [R10]
          end
        end
        OFS_UPPER_CTL:
        begin
          if (wb_sel[0])
          begin
            next_state.upper_counter_control = wb_dat_w[7:0]; // [R03] [R11] [R12]
          end
        end
        OFS_PERIOD:
        begin
          if (wb_sel[0])
          begin
            next_state.period_compare_low = wb_dat_w[7:0];
          end
          if (wb_sel[1])
          begin
            next_state.period_compare_high = wb_dat_w[15:8];
          end
        end
        OFS_SYSCTL_TWO:
        begin
          if (wb_sel[0])
          begin
            // only the three documented bits are kept
            next_state.system_control_two = wb_dat_w[7:0] & 8'he0; // [R13]
          end
        end
        OFS_IRQ_STATUS:
        begin
          if (wb_sel[0] & wb_dat_w[MATCH_IRQ_BIT])
          begin
            next_state.irq_status = 1'b0;
          end
        end
        OFS_IRQ_MASK:
        begin
          if (wb_sel[0])
          begin
            next_state.irq_mask = wb_dat_w[MATCH_IRQ_BIT];
          end
        end
        default:
        begin
          next_state.irq_mask = state.irq_mask;
        end
      endcase
    end

    // set after the clear so a match in the clearing cycle is kept
    if (match)
    begin
      next_state.irq_status = 1'b1; // [R04]
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state.ack                   <= 1'b0;
      state.rdata                 <= 32'h0000_0000;
      state.lower_counter_control <= LOWER_CTL_RESET;
      state.upper_counter_control <= UPPER_CTL_RESET;
      state.period_compare_high   <= PERIOD_RESET[15:8];
      state.period_compare_low    <= PERIOD_RESET[7:0];
      state.system_control_two    <= SYSCTL_RESET;
      state.irq_status            <= IRQ_STATUS_RESET;
      state.irq_mask              <= IRQ_MASK_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // outputs
  assign wb_ack   = state.ack;
  assign wb_dat_r = state.rdata;

  // level, high while an unmasked match is pending
  assign pair_match_irq = state.irq_status & state.irq_mask; // [R04]
  assign pair_running   = run_bit;

  // clock and oscillator sequencing is software's job; these only follow the bits
  assign system_clock_select = state.system_control_two[SYSCLK_SEL_BIT]; // [R13] [R05] [R06]
  assign slow_osc_enable     = state.system_control_two[SLOW_OSC_BIT];   // [R13] [R01]
  assign fast_osc_enable     = state.system_control_two[FAST_OSC_BIT];   // [R13] [R02]

  // flops are never toggled here; nonzero values pass straight to the pins
  assign lower_output_flop = state.lower_counter_control[OUT_FLOP_BIT]; // [R15]
  assign upper_output_flop = state.upper_counter_control[OUT_FLOP_BIT]; // [R15]

endmodule // owc_warmup

// ### tb/owc_warmup_chk.sv
`timescale 1ns/1ps
module owc_warmup_chk
  import owc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic [7:0]  wb_adr,
  input wire logic [3:0]  wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic        wb_ack,
  input wire logic        pair_match_irq,
  input wire logic        pair_running,
  input wire logic        system_clock_select,
  input wire logic        slow_osc_enable,
  input wire logic        fast_osc_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic wr_done = wb_cyc && wb_stb && wb_we && wb_ack && wb_sel[0];
  // ==========================================================
  // bus handshake
  sequence s_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  chk_ack_follows_req: assert property (s_req |=> wb_ack) else $error("ack late");
  chk_ack_one_cycle: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
  chk_ack_has_cause: assert property (wb_ack |-> $past(wb_cyc && wb_stb)) else $error("ack unasked");
  chk_unmapped_zero: assert property (wb_ack && !wb_we && wb_adr == 8'h1c |-> wb_dat_r == 32'h0000_0000)
    else $error("unmapped read not zero");
  // ==========================================================
  // control bits
  chk_run_bit_write: assert property (wr_done && wb_adr == OFS_UPPER_CTL
    |=> pair_running == $past(wb_dat_w[RUN_BIT])) else $error("run bit wrong");
  chk_sysctl_bits: assert property (wr_done && wb_adr == OFS_SYSCTL_TWO
    |=> {fast_osc_enable, slow_osc_enable, system_clock_select} == $past(wb_dat_w[7:5]))
    else $error("sysctl bits wrong");
  chk_run_only_write: assert property (!$stable(pair_running) |-> $past(wb_ack && wb_we))
    else $error("run changed alone");
  // irq rises only from a running match or a mask write
  chk_irq_rise_cause: assert property ($rose(pair_match_irq)
    |-> $past(pair_running) || $past(pair_running, 2) || $past(wb_ack && wb_we)) else $error("irq unasked");
  chk_irq_fall_cause: assert property ($fell(pair_match_irq)
    |-> $past(wb_ack && wb_we) || $past(wb_ack && wb_we, 2)) else $error("irq dropped alone");
endmodule // owc_warmup_chk

bind owc_warmup owc_warmup_chk u_chk (.mclk(mclk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
  .wb_ack(wb_ack), .pair_match_irq(pair_match_irq), .pair_running(pair_running),
  .system_clock_select(system_clock_select), .slow_osc_enable(slow_osc_enable),
  .fast_osc_enable(fast_osc_enable));

// ### tb/owc_warmup_test.sv
`timescale 1ns/1ps
module owc_warmup_test;
  import owc_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] x;} owc_row_t;
  logic        mclk = 0, rst_n = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic [7:0]  wb_adr = 0;
  logic [3:0]  wb_sel = 0, bsel = 4'h3;
  logic [31:0] wb_dat_w = 0, wb_dat_r, q;
  logic        wb_ack, irq, run, csel, sosc, fosc, slow_clock_tick = 0, fast_clock_tick = 0;
  logic        lof, uof;
  int          mismatches = 0, check_count = 0;
  owc_row_t    rows [8];

  owc_warmup dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .slow_clock_tick(slow_clock_tick), .fast_clock_tick(fast_clock_tick), .pair_match_irq(irq),
    .pair_running(run), .system_clock_select(csel), .slow_osc_enable(sosc), .fast_osc_enable(fosc),
    .lower_output_flop(lof), .upper_output_flop(uof));

  always #4 mclk = ~mclk;

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      mismatches++;
    end
  endtask

  // ports are looked at on the falling edge so the write has landed
  task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    wb_cyc <= 1;
    wb_stb <= 1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= bsel;
    wb_dat_w <= {16'h0000, d};
    // no wait limit here; the watchdog ends a hang
    do @(posedge mclk); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 0;
    wb_stb <= 0;
    @(negedge mclk);
  endtask

  task automatic ticks(input int n, input logic fast);
    repeat (n)
    begin
      @(posedge mclk);
      fast_clock_tick <= fast;
      slow_clock_tick <= !fast;
      @(posedge mclk);
      fast_clock_tick <= 0;
      slow_clock_tick <= 0;
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic warmup(input logic [7:0] ctl, input logic fast, input logic [15:0] per);
    bus(1, OFS_LOWER_CTL, {8'h00, ctl});
    bus(1, OFS_UPPER_CTL, 16'h0005);
    bus(1, OFS_PERIOD, per);
    chk("out flops", {lof, uof}, 2'b00);
    bus(1, OFS_UPPER_CTL, 16'h000d);
    chk("running", run, 1);
    ticks(10, !fast);
    bus(0, OFS_COUNT, 0);
    chk("other source", q[15:0], 0);
    ticks(255, fast);
    bus(0, OFS_COUNT, 0);
    chk("count", q[15:0], 16'h00ff);
    bus(0, OFS_IRQ_STATUS, 0);
    chk("no early match", q[0], 0);
    ticks(1, fast);
    bus(0, OFS_COUNT, 0);
    chk("wrap", q[15:0], 0);
    bus(0, OFS_IRQ_STATUS, 0);
    chk("status", q[0], 1);
    bus(1, OFS_UPPER_CTL, 16'h0005);
  endtask

  task automatic test_done;
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // sequence
  initial
  begin
    rows = '{'{OFS_LOWER_CTL, 16'h0043, 16'h0043}, '{OFS_LOWER_CTL, 16'h0063, 16'h0063},
             '{OFS_UPPER_CTL, 16'h0005, 16'h0005}, '{OFS_PERIOD, 16'hff00, 16'hff00},
             '{OFS_SYSCTL_TWO, 16'h00ff, 16'h00e0}, '{OFS_COUNT, 16'h1234, 16'h0000},
             '{8'h1c, 16'h5a5a, 16'h0000}, '{OFS_IRQ_MASK, 16'h0001, 16'h0001}};
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    @(negedge mclk);
    chk("fast osc", fosc, 1);
    chk("irq idle", irq, 0);
    bus(0, OFS_SYSCTL_TWO, 0);
    chk("sysctl", q[7:0], 8'h80);
    foreach (rows[i])
    begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 0);
      chk("row", q[15:0], rows[i].x);
    end
    // only the enabled byte lane lands
    bsel = 4'h2;
    bus(1, OFS_PERIOD, 16'h3355);
    bsel = 4'h3;
    bus(0, OFS_PERIOD, 0);
    chk("byte lanes", q[15:0], 16'h3300);
    // fast to slow, interrupt unmasked
    bus(1, OFS_SYSCTL_TWO, 16'h00c0);
    warmup(8'h43, 0, 16'h0100);
    chk("irq", irq, 1);
    bus(1, OFS_SYSCTL_TWO, 16'h00e0);
    chk("slow selected", {fosc, sosc, csel}, 3'b111);
    bus(1, OFS_SYSCTL_TWO, 16'h0060);
    chk("to slow", {fosc, sosc, csel}, 3'b011);
    bus(1, OFS_IRQ_STATUS, 16'h0001);
    chk("irq clear", irq, 0);
    // stop mid-count must restart from zero
    bus(1, OFS_IRQ_MASK, 0);
    bus(1, OFS_SYSCTL_TWO, 16'h00e0);
    bus(1, OFS_UPPER_CTL, 16'h000d);
    ticks(100, 0);
    bus(0, OFS_COUNT, 0);
    chk("mid count", q[15:0], 16'h0064);
    bus(1, OFS_UPPER_CTL, 16'h0005);
    bus(0, OFS_COUNT, 0);
    chk("stop clears", q[15:0], 0);
    // reserved source never counts
    bus(1, OFS_LOWER_CTL, 16'h0073);
    bus(1, OFS_UPPER_CTL, 16'h000d);
    ticks(4, 0);
    ticks(4, 1);
    bus(0, OFS_COUNT, 0);
    chk("no source", q[15:0], 0);
    bus(1, OFS_UPPER_CTL, 16'h0005);
    // slow to fast, low compare byte ignored, masked first
    warmup(8'h63, 1, 16'h01ff);
    chk("masked", irq, 0);
    bus(1, OFS_IRQ_MASK, 16'h0001);
    chk("unmasked", irq, 1);
    bus(1, OFS_SYSCTL_TWO, 16'h00c0);
    chk("fast selected", {fosc, sosc, csel}, 3'b110);
    bus(1, OFS_SYSCTL_TWO, 16'h0080);
    chk("to fast", {fosc, sosc, csel}, 3'b100);
    // reset in mid-run, held over three edges
    bus(1, OFS_UPPER_CTL, 16'h000d);
    chk("run before reset", run, 1);
    @(posedge mclk);
    rst_n <= 0;
    @(negedge mclk);
    chk("reset run", run, 0);
    chk("reset irq", irq, 0);
    repeat (3) @(posedge mclk);
    rst_n <= 1;
    @(negedge mclk);
    chk("reset osc", {fosc, sosc, csel}, 3'b100);
    bus(0, OFS_UPPER_CTL, 0);
    chk("reset ctl", q[7:0], 8'h00);
    test_done;
  end

  initial
  begin
    #200000;
    mismatches++;
    test_done;
  end
endmodule // owc_warmup_test
